// *** common/tmc_regs.svh ***
// register offsets, field positions, reset values and counts of the timer module
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH

// ----------------------------------------------------------------------------
// register byte offsets on the bus
// ----------------------------------------------------------------------------
`define TMC_OFS_CTRL0 8'h00
`define TMC_OFS_CTRL1 8'h04
`define TMC_OFS_CNT_L 8'h08
`define TMC_OFS_CNT_H 8'h0C
`define TMC_OFS_CMPA_L 8'h10
`define TMC_OFS_CMPA_H 8'h14
`define TMC_OFS_CTRL2 8'h18
`define TMC_OFS_STATUS 8'h1C

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define TMC_CTRL0_RST 8'h00
`define TMC_CTRL1_RST 8'h00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define TMC_CTRL2_EDGE_BIT 0
`define TMC_ST_A_BIT 0
`define TMC_ST_P_BIT 1

// ----------------------------------------------------------------------------
// clock select codes
// ----------------------------------------------------------------------------
`define TMC_CK_SYS4 3'h0
`define TMC_CK_SYS 3'h1
`define TMC_CK_H16 3'h2
`define TMC_CK_H64 3'h3
`define TMC_CK_SUB0 3'h4
`define TMC_CK_SUB1 3'h5

// ----------------------------------------------------------------------------
// counts
// ----------------------------------------------------------------------------
`define TMC_CNT_W 10
`define TMC_PRESC_W 6
`define TMC_PERIOD_W 3

`endif

// *** common/tmc_pkg.sv ***
// types shared by the timer module files
`default_nettype none

package tmc_pkg;

   // -------------------------------------------------------------------------
   // modes and output actions
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      TMC_MODE_CMP,
      TMC_MODE_PULSE,
      TMC_MODE_PWM,
      TMC_MODE_TIMER
   } tmc_mode_t;

   typedef enum logic [1:0] {
      TMC_IO_KEEP,
      TMC_IO_LOW,
      TMC_IO_HIGH,
      TMC_IO_TOGGLE
   } tmc_io_t;

   // -------------------------------------------------------------------------
   // control register layouts
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic pause;
      logic [2:0] clkSel;
      logic enable;
      logic [2:0] period;
   } tmc_ctrl0_t;

   typedef struct packed {
      tmc_mode_t mode;
      tmc_io_t io;
      logic initLvl;
      logic polarity;
      logic dutySwap;
      logic clrOnA;
   } tmc_ctrl1_t;

endpackage : tmc_pkg

`default_nettype wire

// *** core/tmc_sync.sv ***
// two-stage synchroniser for asynchronous pin inputs
`default_nettype none

module tmc_sync #(
   parameter int WIDTH = 2
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } tmc_sync_st_t;

   tmc_sync_st_t s_r;
   tmc_sync_st_t s_nxt;

   // first stage feeds only the second stage
   always_comb begin
      s_nxt = s_r;
      s_nxt.meta = asyncIn;
      s_nxt.stable = s_r.meta;
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign syncOut = s_r.stable;

endmodule // tmc_sync

`default_nettype wire

// *** core/tmc_timer.sv ***
// timer module core: counter, two comparators, output pins, bus registers
//
// Behaviour
// - free-running up-counter compared, match raises interrupt
// - match may clear counter and change pin
// - three-bit select picks counter clock source
// - external pin edges advance the counter
// - separate match events for comparators A and P
// - external clock edge selectable rising or falling
// - single pulse launched by external pin edge
// - second output always inverse of first
// - compare match sets, clears or toggles output
// - pwm waveform drives the same output pins
// - low bytes reached only through holding buffer
// - compare-A low write loads buffer only
// - compare-A high write also copies buffer low
// - high byte read captures low into buffer
// - low byte read returns holding buffer
// - compare, timer and pwm modes supported
// - counter is ten bits wide
// - counter clears on enable rise, overflow, match
// - period value matches top three counter bits
//
// The address map and register access over Wishbone were chosen for this implementation.
`default_nettype none
`include "tmc_regs.svh"

module tmc_timer #(
   parameter int CNT_W = `TMC_CNT_W,
   parameter int PRESC_W = `TMC_PRESC_W
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic extClockTriggerIn,
   input wire logic subsidiaryClock,
   output logic timerOut,
   output logic timerOutInv,
   output logic matchAEvent,
   output logic matchPEvent
);

   localparam int HI_W = CNT_W - 8;
   localparam int LO_W = CNT_W - `TMC_PERIOD_W;

   // -------------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------------
   typedef struct packed {
      tmc_pkg::tmc_ctrl0_t ctrl0;
      tmc_pkg::tmc_ctrl1_t ctrl1;
      logic edgeFall;
      logic [CNT_W-1:0] cmpA;
      logic [CNT_W-1:0] cnt;
      logic [7:0] holdBuf;
      logic [PRESC_W-1:0] presc;
      logic extPrev;
      logic subPrev;
      logic outLvl;
      logic pulseRun;
      logic flagA;
      logic flagP;
      logic irqA;
      logic irqP;
      logic ack;
      logic [7:0] rdData;
      logic outPin;
      logic outPinInv;
   } tmc_core_st_t;

   tmc_core_st_t s_r;
   tmc_core_st_t s_nxt;

   logic [1:0] pinSync;
   logic extSync;
   logic subSync;

   // -------------------------------------------------------------------------
   // pin synchronisation
   // -------------------------------------------------------------------------
   tmc_sync #(
      .WIDTH(2)
   ) u_sync (
      .mclk(mclk),
      .rstn(rstn),
      .asyncIn({subsidiaryClock, extClockTriggerIn}),
      .syncOut(pinSync)
   );

   assign extSync = pinSync[0];
   assign subSync = pinSync[1];

   // -------------------------------------------------------------------------
   // next-state logic
   // -------------------------------------------------------------------------
   always_comb begin
      logic extEdge;
      logic subEdge;
      logic tick;
      logic run;
      logic [CNT_W-1:0] cntInc;
      logic [CNT_W-1:0] duty;
      logic matchA;
      logic matchP;
      logic take;
      logic clrA;
      logic clrP;
      logic enRise;
      logic pwmActive;
      tmc_pkg::tmc_ctrl0_t newCtrl0;
      extEdge = 1'b0;
      subEdge = 1'b0;
      tick = 1'b0;
      run = 1'b0;
      cntInc = '0;
      duty = '0;
      matchA = 1'b0;
      matchP = 1'b0;
      take = 1'b0;
      clrA = 1'b0;
      clrP = 1'b0;
      enRise = 1'b0;
      pwmActive = 1'b0;
      newCtrl0 = s_r.ctrl0;

      s_nxt = s_r;
      s_nxt.irqA = 1'b0;
      s_nxt.irqP = 1'b0;
      s_nxt.ack = 1'b0;
      s_nxt.presc = s_r.presc + 1'b1;
      s_nxt.extPrev = extSync;
      s_nxt.subPrev = subSync;

      // edge on the synchronised pins; software chooses the external pin's active edge, the subsidiary clock counts rising edges only
      if (s_r.edgeFall) begin
         extEdge = ~extSync & s_r.extPrev;
      end else begin
         extEdge = extSync & ~s_r.extPrev;
      end
      subEdge = subSync & ~s_r.subPrev;

      // counter clock source; the internal high clock is taken as mclk
      case (s_r.ctrl0.clkSel)
         `TMC_CK_SYS4: tick = &s_r.presc[1:0];
         `TMC_CK_SYS: tick = 1'b1;
         `TMC_CK_H16: tick = &s_r.presc[3:0];
         `TMC_CK_H64: tick = &s_r.presc[5:0];
         `TMC_CK_SUB0, `TMC_CK_SUB1: tick = subEdge;
         default: tick = extEdge;
      endcase

      // a single pulse counts only while the pulse is out
      run = s_r.ctrl0.enable & ~s_r.ctrl0.pause &
            ((s_r.ctrl1.mode != tmc_pkg::TMC_MODE_PULSE) | s_r.pulseRun);

      // -------------------------------------------------------------------
      // counting and comparison
      // -------------------------------------------------------------------
      cntInc = s_r.cnt + 1'b1;
      // period zero matches on wrap, so overflow needs no separate term
      matchP = tick & run & (cntInc[CNT_W-1 -: `TMC_PERIOD_W] == s_r.ctrl0.period) &
               (cntInc[LO_W-1:0] == '0);
      matchA = tick & run & (cntInc == s_r.cmpA);

      if (tick & run) begin
         s_nxt.cnt = cntInc;
         if ((matchP & ~s_r.ctrl1.clrOnA) | (matchA & s_r.ctrl1.clrOnA)) begin
            s_nxt.cnt = '0;
         end
      end

      s_nxt.irqA = matchA;
      s_nxt.irqP = matchP;

      // -------------------------------------------------------------------
      // output level per mode
      // -------------------------------------------------------------------
      duty = s_r.ctrl1.dutySwap ? {s_r.ctrl0.period, {LO_W{1'b0}}} : s_r.cmpA;
      pwmActive = s_r.cnt < duty;
      unique case (s_r.ctrl1.mode)
         tmc_pkg::TMC_MODE_CMP: begin
            if (matchA) begin
               unique case (s_r.ctrl1.io)
                  tmc_pkg::TMC_IO_KEEP: s_nxt.outLvl = s_r.outLvl;
                  tmc_pkg::TMC_IO_LOW: s_nxt.outLvl = 1'b0;
                  tmc_pkg::TMC_IO_HIGH: s_nxt.outLvl = 1'b1;
                  tmc_pkg::TMC_IO_TOGGLE: s_nxt.outLvl = ~s_r.outLvl;
               endcase
            end
         end
         tmc_pkg::TMC_MODE_PWM: begin
            unique case (s_r.ctrl1.io)
               tmc_pkg::TMC_IO_LOW: s_nxt.outLvl = s_r.ctrl1.initLvl;
               tmc_pkg::TMC_IO_HIGH: begin
                  s_nxt.outLvl = pwmActive ? s_r.ctrl1.initLvl : ~s_r.ctrl1.initLvl;
               end
               default: s_nxt.outLvl = ~s_r.ctrl1.initLvl;
            endcase
         end
         tmc_pkg::TMC_MODE_PULSE: begin
            if (s_r.ctrl0.enable & ~s_r.pulseRun & extEdge) begin
               s_nxt.pulseRun = 1'b1;
               s_nxt.cnt = '0;
            end else if (matchA) begin
               s_nxt.pulseRun = 1'b0;
            end
            s_nxt.outLvl = s_nxt.pulseRun ? s_r.ctrl1.initLvl : ~s_r.ctrl1.initLvl;
         end
         tmc_pkg::TMC_MODE_TIMER: s_nxt.outLvl = s_r.outLvl;
      endcase

      // -------------------------------------------------------------------
      // wishbone slave: one wait state, ack for one cycle
      // -------------------------------------------------------------------
      take = wb_cyc_i & wb_stb_i & ~s_r.ack;
      s_nxt.ack = take;
      if (take & wb_we_i & wb_sel_i[0]) begin
         unique case (wb_adr_i)
            `TMC_OFS_CTRL0: begin
               newCtrl0 = tmc_pkg::tmc_ctrl0_t'(wb_dat_i[7:0]);
               enRise = newCtrl0.enable & ~s_r.ctrl0.enable;
               s_nxt.ctrl0 = newCtrl0;
            end
            `TMC_OFS_CTRL1: s_nxt.ctrl1 = tmc_pkg::tmc_ctrl1_t'(wb_dat_i[7:0]);
            // both low bytes share the one holding buffer
            `TMC_OFS_CNT_L, `TMC_OFS_CMPA_L: s_nxt.holdBuf = wb_dat_i[7:0];
            `TMC_OFS_CMPA_H: s_nxt.cmpA = {wb_dat_i[HI_W-1:0], s_r.holdBuf};
            `TMC_OFS_CTRL2: s_nxt.edgeFall = wb_dat_i[`TMC_CTRL2_EDGE_BIT];
            `TMC_OFS_STATUS: begin
               clrA = wb_dat_i[`TMC_ST_A_BIT];
               clrP = wb_dat_i[`TMC_ST_P_BIT];
            end
            default: s_nxt.rdData = s_r.rdData;
         endcase
      end

      if (take) begin
         s_nxt.rdData = 8'h00;
      end
      if (take & ~wb_we_i) begin
         unique case (wb_adr_i)
            `TMC_OFS_CTRL0: s_nxt.rdData = s_r.ctrl0;
            `TMC_OFS_CTRL1: s_nxt.rdData = s_r.ctrl1;
            `TMC_OFS_CNT_L, `TMC_OFS_CMPA_L: s_nxt.rdData = s_r.holdBuf;
            `TMC_OFS_CNT_H: begin
               s_nxt.rdData = 8'(s_r.cnt >> 8);
               s_nxt.holdBuf = s_r.cnt[7:0];
            end
            `TMC_OFS_CMPA_H: begin
               s_nxt.rdData = 8'(s_r.cmpA >> 8);
               s_nxt.holdBuf = s_r.cmpA[7:0];
            end
            `TMC_OFS_CTRL2: s_nxt.rdData = {7'h00, s_r.edgeFall};
            `TMC_OFS_STATUS: s_nxt.rdData = {6'h00, s_r.flagP, s_r.flagA};
            default: s_nxt.rdData = 8'h00;
         endcase
      end

      // turning the module on restarts count and output
      if (enRise) begin
         s_nxt.cnt = '0;
         s_nxt.outLvl = s_r.ctrl1.initLvl;
         s_nxt.pulseRun = 1'b0;
         if (s_r.ctrl1.mode == tmc_pkg::TMC_MODE_PULSE) begin
            s_nxt.outLvl = ~s_r.ctrl1.initLvl;
         end
      end

      // sticky flags; a match in the clearing cycle is kept
      s_nxt.flagA = (s_r.flagA & ~clrA) | matchA;
      s_nxt.flagP = (s_r.flagP & ~clrP) | matchP;

      // pin pair registered so both edges line up
      s_nxt.outPin = s_nxt.outLvl ^ s_nxt.ctrl1.polarity;
      s_nxt.outPinInv = ~(s_nxt.outLvl ^ s_nxt.ctrl1.polarity);
   end

   // -------------------------------------------------------------------------
   // state register
   // -------------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         s_r <= '0;
         s_r.ctrl0 <= tmc_pkg::tmc_ctrl0_t'(`TMC_CTRL0_RST);
         s_r.ctrl1 <= tmc_pkg::tmc_ctrl1_t'(`TMC_CTRL1_RST);
         s_r.outPinInv <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // -------------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------------
   assign wb_dat_o = {24'h000000, s_r.rdData};
   assign wb_ack_o = s_r.ack;
   assign timerOut = s_r.outPin;
   assign timerOutInv = s_r.outPinInv;
   assign matchAEvent = s_r.irqA;
   assign matchPEvent = s_r.irqP;

endmodule // tmc_timer

`default_nettype wire

// *** verif/tmc_timer_assertions.sv ***
// port-level checks on the timer module
`default_nettype none
`include "tmc_regs.svh"
module tmc_timer_assertions #(
   parameter int CNT_W = 10,
   parameter int PRESC_W = 6
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic extClockTriggerIn,
   input wire logic subsidiaryClock,
   input wire logic timerOut,
   input wire logic timerOutInv,
   input wire logic matchAEvent,
   input wire logic matchPEvent
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   wire logic take = wb_cyc_i & wb_stb_i & !wb_ack_o;
   wire logic hiRd = take & !wb_we_i
      & (wb_adr_i == `TMC_OFS_CNT_H || wb_adr_i == `TMC_OFS_CMPA_H);
   chk_out_inverse: assert property (timerOutInv == !timerOut)
      else $error("inverted output differs");
   chk_ack_taken: assert property (take |=> wb_ack_o)
      else $error("access not acknowledged");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_uncaused: assert property (!take |=> !wb_ack_o)
      else $error("ack without access");
   chk_high_read: assert property (hiRd |=> wb_dat_o[31:2] == 30'h0)
      else $error("high byte wider than two bits");
   chk_unmapped_read: assert property (take && !wb_we_i && wb_adr_i > 8'h1C |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   chk_byte_width: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data above byte");
   chk_period_gap: assert property (matchPEvent |=> !matchPEvent [*8])
      else $error("period match too close");
   cover property (matchAEvent);
   cover property (matchPEvent);
   cover property (wb_ack_o && !wb_we_i);
   cover property ($rose(timerOut));
endmodule // tmc_timer_assertions
bind tmc_timer tmc_timer_assertions #(.CNT_W(CNT_W), .PRESC_W(PRESC_W)) chk (
   .mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .extClockTriggerIn(extClockTriggerIn),
   .subsidiaryClock(subsidiaryClock), .timerOut(timerOut), .timerOutInv(timerOutInv),
   .matchAEvent(matchAEvent), .matchPEvent(matchPEvent));
`default_nettype wire

// *** verif/tmc_pin_model.sv ***
// pin-side model: external count pin and free-running slow clock
`default_nettype none
module tmc_pin_model (
   input wire logic mclk,
   output logic extPin,
   output logic subClk
);
   timeunit 1ns;
   timeprecision 1ps;
   int subDiv = 0;
   initial begin
      extPin = 1'b0;
      subClk = 1'b0;
   end
   // slow clock runs free, one rising edge every 16 mclk
   always @(posedge mclk) begin
      subDiv <= (subDiv == 7) ? 0 : subDiv + 1;
      if (subDiv == 7) begin
         subClk <= !subClk;
      end
   end
   // both levels held 4 cycles so the synchroniser never merges edges
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge mclk);
         extPin <= 1'b1;
         repeat (4) @(posedge mclk);
         extPin <= 1'b0;
         repeat (3) @(posedge mclk);
      end
   endtask
endmodule // tmc_pin_model
`default_nettype wire

// *** verif/tmc_timer_bench.sv ***
// self-checking bench for the timer module
`default_nettype none
`include "tmc_regs.svh"
module tmc_timer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rstn, cyc, stb, we, ack, tOut, tOutInv, evA, evP, extPin, subClk;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] datW, datR, q;
   int errorCnt = 0;
   int totalChecks = 0;
   int aCnt = 0;
   int hiCnt = 0;
   tmc_timer dut (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
      .extClockTriggerIn(extPin), .subsidiaryClock(subClk), .timerOut(tOut),
      .timerOutInv(tOutInv), .matchAEvent(evA), .matchPEvent(evP));
   tmc_pin_model pins (.mclk(mclk), .extPin(extPin), .subClk(subClk));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) if (evA === 1'b1) aCnt <= aCnt + 1;
   // cycles with the output pin high, for pulse and duty widths
   always @(posedge mclk) if (tOut === 1'b1) hiCnt <= hiCnt + 1;
   // ----
   // shared tasks
   // ----
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp) begin
         errorCnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
         input logic [3:0] s);
      int n = 0;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= s;
      adr <= a;
      datW <= {24'h0, d};
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = datR;
      cyc <= 1'b0;
      stb <= 1'b0;
      check("ack", 32'h1, {31'h0, ack});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(a, 1'b1, d, 4'hF);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      bus(a, 1'b0, 8'h00, 4'hF);
      check(what, {24'h0, exp}, q);
   endtask
   // cycles until the chosen match event is seen
   task automatic waitEv(input logic pEv, output int n);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while ((pEv ? evP : evA) !== 1'b1 && n < 5000);
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_reset;
      rd(`TMC_OFS_CTRL0, `TMC_CTRL0_RST, "ctrl0");
      rd(`TMC_OFS_CTRL1, `TMC_CTRL1_RST, "ctrl1");
      rd(8'h20, 8'h00, "unmapped");
      check("outInv", 32'h1, {31'h0, tOutInv});
      $display("done reset");
   endtask
   task automatic t_buffer;
      wr(`TMC_OFS_CMPA_L, 8'h5A);
      rd(`TMC_OFS_CMPA_H, 8'h00, "cmpA high");
      rd(`TMC_OFS_CMPA_L, 8'h00, "cmpA low kept");
      wr(`TMC_OFS_CMPA_L, 8'hA5);
      wr(`TMC_OFS_CMPA_H, 8'h02);
      rd(`TMC_OFS_CMPA_H, 8'h02, "cmpA high");
      rd(`TMC_OFS_CMPA_L, 8'hA5, "cmpA low");
      wr(`TMC_OFS_CMPA_L, 8'h33);
      rd(`TMC_OFS_CMPA_L, 8'h33, "buffer read");
      $display("done buffer");
   endtask
   task automatic t_clock;
      int n;
      int div [5] = '{1, 4, 16, 64, 16};
      logic [2:0] sel [5] = '{`TMC_CK_SYS, `TMC_CK_SYS4, `TMC_CK_H16, `TMC_CK_H64, `TMC_CK_SUB0};
      logic o1;
      wr(`TMC_OFS_CMPA_L, 8'h10);
      wr(`TMC_OFS_CMPA_H, 8'h00);
      wr(`TMC_OFS_CTRL1, 8'h31);
      for (int i = 0; i < 5; i++) begin
         wr(`TMC_OFS_CTRL0, {1'b0, sel[i], 4'h8});
         waitEv(1'b0, n);
         waitEv(1'b0, n);
         check("matchA gap", 16 * div[i], n);
      end
      repeat (3) @(posedge mclk);
      o1 = tOut;
      waitEv(1'b0, n);
      repeat (3) @(posedge mclk);
      check("toggle", {31'h0, !o1}, {31'h0, tOut});
      $display("done clock");
   endtask
   task automatic t_ext;
      int a0;
      wr(`TMC_OFS_CTRL0, 8'h00);
      wr(`TMC_OFS_CMPA_L, 8'h03);
      wr(`TMC_OFS_CMPA_H, 8'h00);
      wr(`TMC_OFS_CTRL0, 8'h68);
      a0 = aCnt;
      pins.pulse(2);
      repeat (8) @(posedge mclk);
      rd(`TMC_OFS_CNT_H, 8'h00, "cnt high");
      rd(`TMC_OFS_CNT_L, 8'h02, "cnt low");
      check("no early match", a0, aCnt);
      pins.pulse(1);
      repeat (8) @(posedge mclk);
      check("rise match", a0 + 1, aCnt);
      wr(`TMC_OFS_CTRL2, 8'h01);
      // low byte lane off: write must be ignored
      bus(`TMC_OFS_CTRL2, 1'b1, 8'h00, 4'hE);
      rd(`TMC_OFS_CTRL2, 8'h01, "byte lane off");
      pins.pulse(3);
      repeat (8) @(posedge mclk);
      check("fall match", a0 + 2, aCnt);
      $display("done ext");
   endtask
   task automatic t_period;
      int n, a0;
      logic [7:0] ctl [2] = '{8'h1A, 8'h18};
      int gap [2] = '{256, 1024};
      wr(`TMC_OFS_CTRL0, 8'h00);
      wr(`TMC_OFS_CTRL1, 8'hC0);
      for (int i = 0; i < 2; i++) begin
         wr(`TMC_OFS_CTRL0, ctl[i]);
         waitEv(1'b1, n);
         a0 = aCnt;
         waitEv(1'b1, n);
         check("matchP gap", gap[i], n);
         check("matchA count", a0 + 1, aCnt);
      end
      rd(`TMC_OFS_STATUS, 8'h03, "flags set");
      wr(`TMC_OFS_CTRL0, 8'h00);
      wr(`TMC_OFS_STATUS, 8'h03);
      rd(`TMC_OFS_STATUS, 8'h00, "flags cleared");
      wr(`TMC_OFS_CTRL0, 8'h98);
      repeat (20) @(posedge mclk);
      rd(`TMC_OFS_CNT_H, 8'h00, "paused high");
      rd(`TMC_OFS_CNT_L, 8'h00, "paused low");
      $display("done period");
   endtask
   task automatic t_pulse;
      int h0, a0;
      wr(`TMC_OFS_CTRL0, 8'h00);
      wr(`TMC_OFS_CMPA_L, 8'h08);
      wr(`TMC_OFS_CMPA_H, 8'h00);
      wr(`TMC_OFS_CTRL2, 8'h00);
      wr(`TMC_OFS_CTRL1, 8'h49);
      wr(`TMC_OFS_CTRL0, 8'h18);
      repeat (2) @(posedge mclk);
      check("pulse idle", 32'h0, {31'h0, tOut});
      h0 = hiCnt;
      a0 = aCnt;
      pins.pulse(1);
      repeat (20) @(posedge mclk);
      check("pulse width", 32'h8, hiCnt - h0);
      check("pulse end", a0 + 1, aCnt);
      $display("done pulse");
   endtask
   task automatic t_pwm;
      int n, h0;
      wr(`TMC_OFS_CTRL0, 8'h00);
      wr(`TMC_OFS_CMPA_L, 8'h20);
      wr(`TMC_OFS_CMPA_H, 8'h00);
      wr(`TMC_OFS_CTRL1, 8'h98);
      repeat (2) @(posedge mclk);
      check("pwm active", 32'h1, {31'h0, tOut});
      wr(`TMC_OFS_CTRL1, 8'h8C);
      repeat (2) @(posedge mclk);
      check("pwm inactive", 32'h1, {31'h0, tOut});
      check("pwm inverse", 32'h0, {31'h0, tOutInv});
      wr(`TMC_OFS_CTRL1, 8'hA8);
      wr(`TMC_OFS_CTRL0, 8'h19);
      waitEv(1'b1, n);
      h0 = hiCnt;
      waitEv(1'b1, n);
      check("pwm period", 32'h80, n);
      check("pwm duty", 32'h20, hiCnt - h0);
      $display("done pwm");
   endtask
   task automatic finishTest;
      $display("checks %0d mismatches %0d", totalChecks, errorCnt);
      if (errorCnt == 0 && totalChecks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #500000;
      errorCnt++;
      finishTest;
   end
   initial begin
      rstn = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      sel = 4'hF;
      adr = 8'h00;
      datW = 32'h0;
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      t_reset;
      t_buffer;
      t_clock;
      t_ext;
      t_period;
      t_pulse;
      t_pwm;
      finishTest;
   end
endmodule // tmc_timer_bench
`default_nettype wire
